/* File: logic/plsim_pkg.sv */
// plsim_pkg: constants for the phy link status and interrupt mask block
// assumes a single 50 MHz system clock and a 5-bit register address port
package plsim_pkg;

  // register addresses on the management register port
  localparam logic [4:0] PLSIM_ADDR_LINK_STATUS   = 5'h18;
  localparam logic [4:0] PLSIM_ADDR_EVENT_ENABLE  = 5'h19;
  localparam logic [4:0] PLSIM_ADDR_EVENT_PENDING = 5'h1a;

  // widths
  localparam int PLSIM_DATA_W  = 16;
  localparam int PLSIM_ADDR_W  = 5;

  // reset values
  localparam logic [15:0] PLSIM_LINK_STATUS_RST   = 16'h0000;
  localparam logic [15:0] PLSIM_EVENT_ENABLE_RST  = 16'h0000;
  localparam logic [15:0] PLSIM_EVENT_PENDING_RST = 16'h0000;

  // link status word field positions
  localparam int PLSIM_LSW_MEDIA_LSB    = 6;
  localparam int PLSIM_LSW_PAUSE_LSB    = 4;
  localparam int PLSIM_LSW_DUPLEX_BIT   = 3;
  localparam int PLSIM_LSW_EEE_BIT      = 2;
  localparam int PLSIM_LSW_SPEED_LSB    = 0;

  // event bit positions, shared by enable and pending registers
  localparam int PLSIM_EV_WAKE_PACKET   = 15;
  localparam int PLSIM_EV_ROLE_ERROR    = 14;
  localparam int PLSIM_EV_NP_RECEIVED   = 13;
  localparam int PLSIM_EV_NP_SENT       = 12;
  localparam int PLSIM_EV_NEG_ERROR     = 11;
  localparam int PLSIM_EV_NEG_DONE      = 10;
  localparam int PLSIM_EV_FIFO_OVERFLOW = 9;
  localparam int PLSIM_EV_SYNC_REF_LOST = 8;
  localparam int PLSIM_EV_DOWNSPEED     = 5;
  localparam int PLSIM_EV_POLARITY      = 4;
  localparam int PLSIM_EV_CROSSOVER     = 3;
  localparam int PLSIM_EV_DUPLEX_CHANGE = 2;
  localparam int PLSIM_EV_SPEED_CHANGE  = 1;
  localparam int PLSIM_EV_LINK_CHANGE   = 0;

  // implemented event bits: 7:6 are reserved and read as zero
  localparam logic [15:0] PLSIM_EVENT_IMPL_MASK = 16'hff3f;

  // field encodings
  localparam logic [1:0] PLSIM_MEDIA_TWISTED_PAIR    = 2'h0;
  localparam logic [1:0] PLSIM_MEDIA_FIBER           = 2'h1;
  localparam logic [1:0] PLSIM_MEDIA_SECOND_MAC_PORT = 2'h2;
  localparam logic [1:0] PLSIM_MEDIA_SGMII           = 2'h3;
  localparam logic [1:0] PLSIM_SPEED_10              = 2'h0;
  localparam logic [1:0] PLSIM_SPEED_100             = 2'h1;
  localparam logic [1:0] PLSIM_SPEED_1000            = 2'h2;
  localparam logic [1:0] PLSIM_SPEED_SPECIAL         = 2'h3;
  localparam logic       PLSIM_HALF_DUPLEX           = 1'b0;
  localparam logic       PLSIM_FULL_DUPLEX           = 1'b1;

  // complete register state of the block
  typedef struct packed {
    logic [15:0] link_status_word;
    logic [15:0] event_interrupt_enable;
    logic [15:0] event_pending_flags;
    logic [15:0] rdata;
    logic        rvalid;
    logic        irq;
  } plsim_state_t;

endpackage

/* File: logic/plsim_top.sv */
// plsim_top: link status word, event enable mask, sticky event flags
// and the management interrupt pin of an integrated phy
// assumes register requests come from the phy's management serial
// engine as one-cycle strobes, synchronous to sys_clk_i
//
// Contract
// - bits 7:6 of the link status word report the active media interface.
// - bits 5:4 of the link status word report the resolved pause outcome.
// - bit 3 of the link status word reports duplex, 0 half and 1 full.
// - bit 2 of the link status word reports whether energy saving was resolved on.
// - bits 1:0 of the link status word encode the speed as 10, 100, 1000 or special.
// - bits 15:8 of the link status word are reserved, read zero and ignore writes.
// - the interrupt pin rises only for sources whose enable bit is 1.
// - reading the pending flags clears all but events arriving in that access, and drops the pin unless one of those is enabled.
// - enable bit 15 lets a wake packet event raise the pin.
// - enable bit 14 lets a role resolution error raise the pin.
// - enable bit 13 lets a received next page raise the pin.
// - enable bit 12 lets a sent next page raise the pin.
// - enable bit 11 lets a negotiation error raise the pin.
// - enable bit 10 lets negotiation completion raise the pin.
// - enable bits 2, 1, 0 let duplex, speed and link state changes raise the pin.
// - enable bits 9, 8, 5, 4, 3 let fifo overflow, sync loss, downspeed, polarity and crossover raise the pin.
`timescale 1ns/100ps

module plsim_top
  import plsim_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_n_i,

  // management register port
  input  wire logic [PLSIM_ADDR_W-1:0] reg_addr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic                    reg_wr_i,
  input  wire logic [PLSIM_DATA_W-1:0] reg_wdata_i,
  output logic      [PLSIM_DATA_W-1:0] reg_rdata_o,
  output logic                         reg_rvalid_o,

  // resolved link state from the phy core
  input  wire logic [1:0]              media_select_i,
  input  wire logic [1:0]              pause_resolution_i,
  input  wire logic                    duplex_flag_i,
  input  wire logic                    eee_resolved_i,
  input  wire logic [1:0]              link_speed_i,

  // one-cycle event strobes from the phy core
  input  wire logic                    wake_packet_event_i,
  input  wire logic                    role_resolution_error_i,
  input  wire logic                    next_page_received_i,
  input  wire logic                    next_page_sent_i,
  input  wire logic                    negotiation_error_i,
  input  wire logic                    negotiation_done_i,
  input  wire logic                    mgmt_fifo_overflow_i,
  input  wire logic                    sync_ref_lost_i,
  input  wire logic                    downspeed_event_i,
  input  wire logic                    polarity_change_i,
  input  wire logic                    crossover_change_i,
  input  wire logic                    duplex_change_i,
  input  wire logic                    speed_change_i,
  input  wire logic                    link_state_change_i,

  // management interrupt, active high
  output logic                         mgmt_irq_pin_o
);

  plsim_state_t state_reg;
  plsim_state_t state_next;

  logic [15:0] event_hits;
  logic [15:0] link_word;
  logic        read_status;
  logic        read_enable;
  logic        read_pending;
  logic        write_enable;

  // gather event strobes into their bit positions
  always_comb begin
    event_hits = 16'h0000;
    event_hits[PLSIM_EV_WAKE_PACKET]   = wake_packet_event_i;
    event_hits[PLSIM_EV_ROLE_ERROR]    = role_resolution_error_i;
    event_hits[PLSIM_EV_NP_RECEIVED]   = next_page_received_i;
    event_hits[PLSIM_EV_NP_SENT]       = next_page_sent_i;
    event_hits[PLSIM_EV_NEG_ERROR]     = negotiation_error_i;
    event_hits[PLSIM_EV_NEG_DONE]      = negotiation_done_i;
    event_hits[PLSIM_EV_FIFO_OVERFLOW] = mgmt_fifo_overflow_i;
    event_hits[PLSIM_EV_SYNC_REF_LOST] = sync_ref_lost_i;
    event_hits[PLSIM_EV_DOWNSPEED]     = downspeed_event_i;
    event_hits[PLSIM_EV_POLARITY]      = polarity_change_i;
    event_hits[PLSIM_EV_CROSSOVER]     = crossover_change_i;
    event_hits[PLSIM_EV_DUPLEX_CHANGE] = duplex_change_i;
    event_hits[PLSIM_EV_SPEED_CHANGE]  = speed_change_i;
    event_hits[PLSIM_EV_LINK_CHANGE]   = link_state_change_i;
  end

  // assemble the link status word from the phy core state
  always_comb begin
    link_word = 16'h0000;
    link_word[PLSIM_LSW_MEDIA_LSB +: 2] = media_select_i;
    link_word[PLSIM_LSW_PAUSE_LSB +: 2] = pause_resolution_i;
    link_word[PLSIM_LSW_DUPLEX_BIT]     = duplex_flag_i;
    link_word[PLSIM_LSW_EEE_BIT]        = eee_resolved_i;
    link_word[PLSIM_LSW_SPEED_LSB +: 2] = link_speed_i;
  end

  // address decode
  always_comb begin
    read_status  = reg_rd_i && (reg_addr_i == PLSIM_ADDR_LINK_STATUS);
    read_enable  = reg_rd_i && (reg_addr_i == PLSIM_ADDR_EVENT_ENABLE);
    read_pending = reg_rd_i && (reg_addr_i == PLSIM_ADDR_EVENT_PENDING);
    write_enable = reg_wr_i && (reg_addr_i == PLSIM_ADDR_EVENT_ENABLE);
  end

  // next state
  always_comb begin
    state_next = state_reg;

    // link status tracks the core every cycle, read only
    state_next.link_status_word = link_word;

    // enable mask, reserved bits held at zero
    if (write_enable) begin
      state_next.event_interrupt_enable = reg_wdata_i & PLSIM_EVENT_IMPL_MASK;
    end

    // sticky flags: read clears, a new event in the same cycle survives
    if (read_pending) begin
      state_next.event_pending_flags = event_hits & PLSIM_EVENT_IMPL_MASK;
    end else begin
      state_next.event_pending_flags = (state_reg.event_pending_flags | event_hits)
                                       & PLSIM_EVENT_IMPL_MASK;
    end

    // read data, one cycle after the strobe
    state_next.rvalid = reg_rd_i;
    if (read_status) begin
      state_next.rdata = state_reg.link_status_word;
    end else if (read_enable) begin
      state_next.rdata = state_reg.event_interrupt_enable;
    end else if (read_pending) begin
      state_next.rdata = state_reg.event_pending_flags;
    end else if (reg_rd_i) begin
      state_next.rdata = 16'h0000;
    end

    // pin is the OR of enabled latched flags
    state_next.irq = |(state_next.event_pending_flags &
                       state_next.event_interrupt_enable);
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_reg.link_status_word       <= PLSIM_LINK_STATUS_RST;
      state_reg.event_interrupt_enable <= PLSIM_EVENT_ENABLE_RST;
      state_reg.event_pending_flags    <= PLSIM_EVENT_PENDING_RST;
      state_reg.rdata                  <= 16'h0000;
      state_reg.rvalid                 <= 1'b0;
      state_reg.irq                    <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_o    = state_reg.rdata;
  assign reg_rvalid_o   = state_reg.rvalid;
  assign mgmt_irq_pin_o = state_reg.irq;

endmodule

/* File: tb/plsim_checker.sv */
// plsim_checker: port assertions for plsim_top
// assumes one clock and a synchronous active low reset
`timescale 1ns/100ps
module plsim_checker
  import plsim_pkg::*;
(
  // clock, reset, register port
  input wire logic        sys_clk_i, reset_n_i, reg_rd_i, reg_wr_i,
  input wire logic [4:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i, reg_rdata_o,
  input wire logic        reg_rvalid_o, mgmt_irq_pin_o,
  // link state and events
  input wire logic [1:0]  media_select_i, pause_resolution_i, link_speed_i,
  input wire logic        duplex_flag_i, eee_resolved_i, wake_packet_event_i,
  input wire logic        role_resolution_error_i, next_page_received_i, next_page_sent_i,
  input wire logic        negotiation_error_i, negotiation_done_i, mgmt_fifo_overflow_i,
  input wire logic        sync_ref_lost_i, downspeed_event_i, polarity_change_i,
  input wire logic        crossover_change_i, duplex_change_i, speed_change_i,
  input wire logic        link_state_change_i
);
  wire logic [7:0] lsw_in = {media_select_i, pause_resolution_i, duplex_flag_i,
                             eee_resolved_i, link_speed_i};
  wire logic any_ev = |{wake_packet_event_i, role_resolution_error_i,
    next_page_received_i, next_page_sent_i, negotiation_error_i, negotiation_done_i,
    mgmt_fifo_overflow_i, sync_ref_lost_i, downspeed_event_i, polarity_change_i,
    crossover_change_i, duplex_change_i, speed_change_i, link_state_change_i};
  wire logic en_wr = reg_wr_i && reg_addr_i == PLSIM_ADDR_EVENT_ENABLE;
  wire logic pend_rd = reg_rd_i && reg_addr_i == PLSIM_ADDR_EVENT_PENDING;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  rvalid_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read got no answer");
  rvalid_only_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("answer without read");
  status_read_a: assert property ($past(reset_n_i) && reg_rd_i && reg_addr_i ==
    PLSIM_ADDR_LINK_STATUS |=> reg_rdata_o == {8'h00, $past(lsw_in, 2)})
    else $error("status word mismatch");
  mask_zero_a: assert property (en_wr && reg_wdata_i == 16'h0000 |=> !mgmt_irq_pin_o)
    else $error("irq with all sources masked");
  rise_cause_a: assert property ($rose(mgmt_irq_pin_o) |-> $past(any_ev || en_wr))
    else $error("irq rose without cause");
  irq_hold_a: assert property (mgmt_irq_pin_o && !pend_rd && !en_wr |=> mgmt_irq_pin_o)
    else $error("irq dropped without read");
  read_clear_a: assert property (pend_rd && !any_ev && !en_wr |=> !mgmt_irq_pin_o)
    else $error("irq held after pending read");
  enable_resv_a: assert property (reg_rd_i && reg_addr_i == PLSIM_ADDR_EVENT_ENABLE
    |=> reg_rdata_o[7:6] == 2'h0) else $error("reserved enable bits set");
  cover property (pend_rd ##1 reg_rdata_o != 16'h0000);
  cover property ($rose(mgmt_irq_pin_o));
  cover property ($fell(mgmt_irq_pin_o));
  cover property (pend_rd && any_ev);
endmodule
bind plsim_top plsim_checker u_chk (.*);

/* File: tb/plsim_mgmt_model.sv */
// plsim_mgmt_model: management side register master
// assumes one-cycle strobes launched at the falling edge
`timescale 1ns/100ps
module plsim_mgmt_model (
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i,
  output logic      [4:0]  reg_addr_o,
  output logic             reg_rd_o,
  output logic             reg_wr_o,
  output logic      [15:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 5'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge sys_clk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, v, 1'b1};
    @(negedge sys_clk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~v, 1'b0};
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(negedge sys_clk_i);
    {reg_addr_o, reg_rd_o} = {a, 1'b1};
    @(negedge sys_clk_i);
    v = reg_rvalid_i ? reg_rdata_i : 16'hxxxx;
    {reg_addr_o, reg_rd_o} = {~a, 1'b0};
  endtask
endmodule

/* File: tb/plsim_tb.sv */
// testbench: status table, per event masking, sticky flags, reset
// assumes plsim_top with its checker bound and the register model
`timescale 1ns/100ps
module testbench;
  import plsim_pkg::*;
  typedef struct { logic [7:0] in; logic [15:0] exp; } plsim_row_t;
  plsim_row_t  rows [4] = '{'{8'h00, 16'h0000}, '{8'h55, 16'h0055},
                            '{8'haa, 16'h00aa}, '{8'hff, 16'h00ff}};
  logic        sys_clk_i, reset_n_i, reg_rd_i, reg_wr_i, reg_rvalid_o, mgmt_irq_pin_o;
  logic [4:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, ev, d, b;
  logic [7:0]  lsw;
  int          n_errors = 0;
  int          n_compared = 0;
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  plsim_top dut (.*, .media_select_i(lsw[7:6]), .pause_resolution_i(lsw[5:4]),
    .duplex_flag_i(lsw[3]), .eee_resolved_i(lsw[2]), .link_speed_i(lsw[1:0]),
    .wake_packet_event_i(ev[15]), .role_resolution_error_i(ev[14]),
    .next_page_received_i(ev[13]), .next_page_sent_i(ev[12]), .negotiation_error_i(ev[11]),
    .negotiation_done_i(ev[10]), .mgmt_fifo_overflow_i(ev[9]), .sync_ref_lost_i(ev[8]),
    .downspeed_event_i(ev[5]), .polarity_change_i(ev[4]), .crossover_change_i(ev[3]),
    .duplex_change_i(ev[2]), .speed_change_i(ev[1]), .link_state_change_i(ev[0]));
  plsim_mgmt_model u_mgmt (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o), .reg_addr_o(reg_addr_i), .reg_rd_o(reg_rd_i),
    .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic pulse(input logic [15:0] v);
    @(negedge sys_clk_i) ev = v;
    @(negedge sys_clk_i) ev = 16'h0000;
  endtask
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
  initial begin
    {reset_n_i, lsw, ev} = '0;
    repeat (5) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < 2; i++) begin
      u_mgmt.rd(PLSIM_ADDR_EVENT_ENABLE + 5'(i), d);
      chk(d, 16'h0000);
    end
    $display("test reset values done");
    foreach (rows[i]) begin
      lsw = rows[i].in;
      u_mgmt.rd(PLSIM_ADDR_LINK_STATUS, d);
      chk(d, rows[i].exp);
    end
    lsw = 8'h3c;
    u_mgmt.wr(PLSIM_ADDR_LINK_STATUS, 16'h00ff);
    u_mgmt.rd(PLSIM_ADDR_LINK_STATUS, d);
    chk(d, 16'h003c);
    u_mgmt.wr(PLSIM_ADDR_EVENT_ENABLE, 16'hffff);
    u_mgmt.rd(PLSIM_ADDR_EVENT_ENABLE, d);
    chk(d, 16'hff3f);
    u_mgmt.rd(5'h1f, d);
    chk(d, 16'h0000);
    $display("test status table done");
    for (int i = 0; i < 16; i++) begin
      if (PLSIM_EVENT_IMPL_MASK[i]) begin
        b = 16'h0001 << i;
        u_mgmt.wr(PLSIM_ADDR_EVENT_ENABLE, ~b & 16'hff3f);
        pulse(b);
        chk(16'(mgmt_irq_pin_o), 16'h0000);
        u_mgmt.rd(PLSIM_ADDR_EVENT_PENDING, d);
        chk(d, b);
        u_mgmt.wr(PLSIM_ADDR_EVENT_ENABLE, b);
        pulse(b);
        chk(16'(mgmt_irq_pin_o), 16'h0001);
        u_mgmt.rd(PLSIM_ADDR_EVENT_PENDING, d);
        chk(d, b);
        chk(16'(mgmt_irq_pin_o), 16'h0000);
      end
    end
    $display("test event sources done");
    u_mgmt.wr(PLSIM_ADDR_EVENT_ENABLE, 16'h0000);
    pulse(16'h0401);
    pulse(16'h8000);
    chk(16'(mgmt_irq_pin_o), 16'h0000);
    u_mgmt.wr(PLSIM_ADDR_EVENT_ENABLE, 16'h8000);
    chk(16'(mgmt_irq_pin_o), 16'h0001);
    u_mgmt.rd(PLSIM_ADDR_EVENT_PENDING, d);
    chk(d, 16'h8401);
    fork
      u_mgmt.rd(PLSIM_ADDR_EVENT_PENDING, d);
      pulse(16'h8000);
    join
    chk(d, 16'h0000);
    chk(16'(mgmt_irq_pin_o), 16'h0001);
    $display("test set over clear done");
    pulse(16'h8000);
    reset_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    chk(16'(mgmt_irq_pin_o), 16'h0000);
    u_mgmt.rd(PLSIM_ADDR_EVENT_PENDING, d);
    chk(d, 16'h0000);
    $display("test sticky and reset done");
    test_done;
  end
endmodule
